// ===== hw/fbp_pkg.sv
// constants and types shared by the flash bus pin interface
package fbp_pkg;
  // widths of the pin buses
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  localparam int CTRL_W = 6;
  // density select codes and the address bits each one uses
  localparam logic [1:0] DENS_32M  = 2'h0;
  localparam logic [1:0] DENS_64M  = 2'h1;
  localparam logic [1:0] DENS_128M = 2'h2;
  localparam logic [ADDR_W-1:0] MASK_32M  = 23'h1fffff;
  localparam logic [ADDR_W-1:0] MASK_64M  = 23'h3fffff;
  localparam logic [ADDR_W-1:0] MASK_128M = 23'h7fffff;
  // read configuration word: field positions and reset value
  localparam int RCR_ASYNC_BIT = 15;
  localparam int RCR_WAIT_POL_BIT = 10;
  localparam logic [DATA_W-1:0] RCR_RST = 16'h8400;
  // bit positions of the synchronised control pins in the core domain
  localparam int C_ADV = 0;
  localparam int C_CE  = 1;
  localparam int C_OE  = 2;
  localparam int C_WE  = 3;
  localparam int C_RST = 4;
  localparam int C_WP  = 5;
  localparam logic [CTRL_W-1:0] CTRL_IDLE = 6'h3f;
  // link-domain synchroniser: adv, ce, async mode, wait polarity, address
  localparam int L_W = ADDR_W + 4;
  localparam logic [L_W-1:0] L_IDLE = {4'hf, 23'h000000};
  // synchronous burst sequencer
  typedef enum logic [1:0] {
    LST_IDLE  = 2'b00,
    LST_ISSUE = 2'b01,
    LST_FETCH = 2'b10,
    LST_READY = 2'b11
  } fbp_link_st_t;
endpackage

// ===== hw/fbp_xfer_if.sv
// word handshake carrier between the two clock domains
`timescale 1ns/1ps
`default_nettype none
interface fbp_xfer_if #(
  parameter int W = 16
) ();
  logic         src_valid;
  logic [W-1:0] src_data;
  logic         src_busy;
  logic         dst_valid;
  logic [W-1:0] dst_data;
  modport src (output src_valid, output src_data, input src_busy);
  modport mover (
    input  src_valid,
    input  src_data,
    output src_busy,
    output dst_valid,
    output dst_data
  );
  modport dst (input dst_valid, input dst_data);
endinterface
`default_nettype wire

// ===== hw/fbp_sync_bits.sv
// two-flop level synchroniser, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module fbp_sync_bits #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      // first flop feeds only the second
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta[i] <= RST_VAL[i];
          q[i]    <= RST_VAL[i];
        end else begin
          meta[i] <= d[i];
          q[i]    <= meta[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== hw/fbp_word_xfer.sv
// toggle handshake moving one held word across clock domains
`timescale 1ns/1ps
`default_nettype none
module fbp_word_xfer #(
  parameter int W = 16
) (
  input  wire logic src_clk,
  input  wire logic dst_clk,
  input  wire logic rst,
  fbp_xfer_if.mover x
);
  logic         req_t;
  logic         ack_t;
  logic         req_s;
  logic         req_q;
  logic         ack_s;
  logic [W-1:0] hold;

  // source side: hold word, flip request
  always_ff @(posedge src_clk or posedge rst) begin
    if (rst) begin
      req_t <= 1'b0;
      hold  <= '0;
    end else if (x.src_valid && !x.src_busy) begin
      req_t <= ~req_t;
      hold  <= x.src_data;
    end
  end

  assign x.src_busy = req_t ^ ack_s;

  fbp_sync_bits #(.W(1), .RST_VAL(1'b0)) u_req_sync (
    .clk (dst_clk),
    .rst (rst),
    .d   (req_t),
    .q   (req_s)
  );

  // destination side: edge of request gives one pulse
  always_ff @(posedge dst_clk or posedge rst) begin
    if (rst) begin
      req_q       <= 1'b0;
      ack_t       <= 1'b0;
      x.dst_valid <= 1'b0;
      x.dst_data  <= '0;
    end else begin
      req_q       <= req_s;
      ack_t       <= req_s;
      x.dst_valid <= req_s ^ req_q;
      if (req_s ^ req_q) begin
        x.dst_data <= hold;
      end
    end
  end

  fbp_sync_bits #(.W(1), .RST_VAL(1'b0)) u_ack_sync (
    .clk (src_clk),
    .rst (rst),
    .d   (ack_t),
    .q   (ack_s)
  );
endmodule
`default_nettype wire

// ===== hw/fbp_flash_port.sv
// pin-level host port of a 16-bit flash device
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_port (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         bus_clk,
  input  wire logic [fbp_pkg::ADDR_W-1:0]   addr_in,
  input  wire logic [fbp_pkg::DATA_W-1:0]   dq_in,
  output var  logic [fbp_pkg::DATA_W-1:0]   dq_out,
  output var  logic                         dq_oe,
  input  wire logic                         addr_valid_n,
  input  wire logic                         chip_en_n,
  input  wire logic                         out_en_n,
  input  wire logic                         write_en_n,
  input  wire logic                         reset_pin_n,
  input  wire logic                         write_prot_n,
  output var  logic                         wait_out,
  output var  logic                         wait_oe,
  input  wire logic [1:0]                   dens_sel,
  input  wire logic                         cfg_wr,
  input  wire logic [fbp_pkg::DATA_W-1:0]   cfg_word,
  output var  logic                         arr_rd_en,
  output var  logic [fbp_pkg::ADDR_W-1:0]   arr_rd_addr,
  input  wire logic [fbp_pkg::DATA_W-1:0]   arr_rd_data,
  output var  logic                         wr_valid,
  output var  logic [fbp_pkg::ADDR_W-1:0]   wr_addr,
  output var  logic [fbp_pkg::DATA_W-1:0]   wr_data,
  output var  logic                         auto_rst,
  output var  logic                         standby,
  output var  logic                         lockdown_en,
  input  wire logic                         unlock_req,
  input  wire logic                         unlock_blk_locked,
  output var  logic                         unlock_ok,
  output var  logic                         unlock_refused
);
  localparam int AW = fbp_pkg::ADDR_W;
  localparam int DW = fbp_pkg::DATA_W;
  localparam int CW = fbp_pkg::CTRL_W;
  localparam int SW = CW + AW + DW;

  // core-domain synchronised pins
  logic [SW-1:0] c_sync;
  logic [CW-1:0] c_ctl;
  logic [AW-1:0] c_pin_addr;
  logic [DW-1:0] c_pin_dq;
  logic          c_we_q;
  logic [AW-1:0] c_addr;
  logic [AW-1:0] addr_mask;
  logic [AW-1:0] we_addr;
  logic [DW-1:0] we_data;
  logic [DW-1:0] rcr;
  logic          rd_cycle;
  logic          rd_pend;
  logic          rd_from_link;
  logic          rd_link_req;
  logic [DW-1:0] dq_core;
  logic [DW-1:0] d_hold;
  logic          d_send;
  logic          sync_sel;

  // link-domain state
  logic [fbp_pkg::L_W-1:0] l_sync;
  logic                    l_adv_n;
  logic                    l_adv_q;
  logic                    l_ce_n;
  logic                    l_async;
  logic                    l_pol;
  logic [AW-1:0]           l_addr;
  logic [AW-1:0]           bctr;
  logic [DW-1:0]           dq_link;
  logic                    wait_lvl;
  fbp_pkg::fbp_link_st_t   lst;
  fbp_pkg::fbp_link_st_t   next_lst;

  fbp_xfer_if #(.W(AW)) a_if ();
  fbp_xfer_if #(.W(DW)) d_if ();

  // pins into the core clock
  fbp_sync_bits #(
    .W       (SW),
    .RST_VAL ({fbp_pkg::CTRL_IDLE, {(AW + DW){1'b0}}})
  ) u_core_sync (
    .clk (ref_clk),
    .rst (rst),
    .d   ({write_prot_n, reset_pin_n, write_en_n, out_en_n,
           chip_en_n, addr_valid_n, addr_in, dq_in}),
    .q   (c_sync)
  );

  assign c_ctl      = c_sync[SW-1 -: CW];
  assign c_pin_addr = c_sync[DW +: AW];
  assign c_pin_dq   = c_sync[DW-1:0];

  always_comb begin
    unique case (dens_sel)
      fbp_pkg::DENS_32M: addr_mask = fbp_pkg::MASK_32M;
      fbp_pkg::DENS_64M: addr_mask = fbp_pkg::MASK_64M;
      default:           addr_mask = fbp_pkg::MASK_128M;
    endcase
  end

  // address follows pins while valid strobe is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c_addr <= '0;
    end else if (!c_ctl[fbp_pkg::C_ADV]) begin
      c_addr <= c_pin_addr & addr_mask;
    end
  end

  // read configuration, back to async on reset pin
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rcr <= fbp_pkg::RCR_RST;
    end else if (!c_ctl[fbp_pkg::C_RST]) begin
      rcr <= fbp_pkg::RCR_RST;
    end else if (cfg_wr) begin
      rcr <= cfg_word;
    end
  end

  assign sync_sel = !rcr[fbp_pkg::RCR_ASYNC_BIT];

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      auto_rst    <= 1'b1;
      standby     <= 1'b1;
      lockdown_en <= 1'b0;
    end else begin
      auto_rst    <= !c_ctl[fbp_pkg::C_RST];
      standby     <= c_ctl[fbp_pkg::C_CE];
      lockdown_en <= !c_ctl[fbp_pkg::C_WP];
    end
  end

  // unlock refused for locked-down block under protect
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      unlock_ok      <= 1'b0;
      unlock_refused <= 1'b0;
    end else begin
      unlock_ok      <= unlock_req &&
                        !(lockdown_en && unlock_blk_locked);
      unlock_refused <= unlock_req && lockdown_en && unlock_blk_locked;
    end
  end

  // hold address and data while strobe low, emit on rise
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      c_we_q   <= 1'b1;
      we_addr  <= '0;
      we_data  <= '0;
      wr_valid <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
    end else begin
      c_we_q   <= c_ctl[fbp_pkg::C_WE];
      wr_valid <= 1'b0;
      if (!c_ctl[fbp_pkg::C_WE]) begin
        we_addr <= c_pin_addr & addr_mask;
        we_data <= c_pin_dq;
      end
      // writes refused while reset pin low
      if (c_ctl[fbp_pkg::C_WE] && !c_we_q &&
          !c_ctl[fbp_pkg::C_CE] && c_ctl[fbp_pkg::C_RST]) begin
        wr_valid <= 1'b1;
        wr_addr  <= we_addr;
        wr_data  <= we_data;
      end
    end
  end

  // a read cycle is selected, output enabled, strobe high
  assign rd_cycle = !c_ctl[fbp_pkg::C_CE] && !c_ctl[fbp_pkg::C_OE] &&
                    c_ctl[fbp_pkg::C_WE];

  // array read: burst fetches first, else async read of held address, or of pin address while strobe low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      arr_rd_en    <= 1'b0;
      arr_rd_addr  <= '0;
      rd_pend      <= 1'b0;
      rd_from_link <= 1'b0;
      rd_link_req  <= 1'b0;
    end else begin
      rd_pend      <= arr_rd_en;
      rd_from_link <= rd_link_req; // origin travels with rd_pend
      rd_link_req  <= 1'b0;
      arr_rd_en    <= 1'b0;
      if (a_if.dst_valid) begin
        arr_rd_en    <= 1'b1;
        arr_rd_addr  <= a_if.dst_data & addr_mask;
        rd_link_req  <= 1'b1;
      end else if (rd_cycle && !sync_sel) begin
        arr_rd_en   <= 1'b1;
        arr_rd_addr <= c_ctl[fbp_pkg::C_ADV] ? c_addr : c_pin_addr & addr_mask;
      end
    end
  end

  // returned word to the pins or to the burst side
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      dq_core <= '0;
      d_hold  <= '0;
      d_send  <= 1'b0;
    end else begin
      if (rd_pend && rd_from_link) begin
        d_hold <= arr_rd_data;
        d_send <= 1'b1;
      end else if (d_send && !d_if.src_busy) begin
        d_send <= 1'b0;
      end
      if (rd_pend && !rd_from_link) begin
        dq_core <= arr_rd_data;
      end
    end
  end

  assign d_if.src_valid = d_send;
  assign d_if.src_data  = d_hold;

  // drivers float unless selected and output enabled
  assign dq_oe   = rd_cycle;
  assign dq_out  = sync_sel ? dq_link : dq_core;
  // wait floats only on deselect, not on output enable
  assign wait_oe = !c_ctl[fbp_pkg::C_CE];

  // pins and configuration into the bus clock
  fbp_sync_bits #(
    .W       (fbp_pkg::L_W),
    .RST_VAL (fbp_pkg::L_IDLE)
  ) u_link_sync (
    .clk (bus_clk),
    .rst (rst),
    .d   ({addr_valid_n, chip_en_n, rcr[fbp_pkg::RCR_ASYNC_BIT],
           rcr[fbp_pkg::RCR_WAIT_POL_BIT], addr_in}),
    .q   (l_sync)
  );

  assign l_adv_n = l_sync[AW+3];
  assign l_ce_n  = l_sync[AW+2];
  assign l_async = l_sync[AW+1];
  assign l_pol   = l_sync[AW];
  assign l_addr  = l_sync[AW-1:0];

  // burst sequencer next state
  always_comb begin
    next_lst = lst;
    unique case (lst)
      fbp_pkg::LST_IDLE:  next_lst = fbp_pkg::LST_IDLE;
      fbp_pkg::LST_ISSUE: if (!a_if.src_busy) begin
        next_lst = fbp_pkg::LST_FETCH;
      end
      fbp_pkg::LST_FETCH: if (d_if.dst_valid) begin
        next_lst = fbp_pkg::LST_READY;
      end
      fbp_pkg::LST_READY: next_lst = fbp_pkg::LST_ISSUE;
    endcase
    // first edge seeing the strobe low reloads the address
    if (!l_adv_n && l_adv_q) begin
      next_lst = fbp_pkg::LST_ISSUE;
    end
    if (l_ce_n || l_async) begin
      next_lst = fbp_pkg::LST_IDLE;
    end
  end

  // burst counter loads on address catch, steps per word
  always_ff @(posedge bus_clk or posedge rst) begin
    if (rst) begin
      lst     <= fbp_pkg::LST_IDLE;
      l_adv_q <= 1'b1;
      bctr    <= '0;
      dq_link <= '0;
    end else begin
      lst     <= next_lst;
      l_adv_q <= l_adv_n;
      if (!l_adv_n && l_adv_q) begin
        bctr <= l_addr;
      end else if (lst == fbp_pkg::LST_READY) begin
        bctr <= bctr + 23'h000001;
      end
      if (d_if.dst_valid) begin
        dq_link <= d_if.dst_data;
      end
    end
  end

  assign a_if.src_valid = (lst == fbp_pkg::LST_ISSUE);
  assign a_if.src_data  = bctr;

  // wait active while a burst word is pending
  always_ff @(posedge bus_clk or posedge rst) begin
    if (rst) begin
      wait_lvl <= 1'b0;
    end else begin
      wait_lvl <= ((next_lst == fbp_pkg::LST_ISSUE) ||
                   (next_lst == fbp_pkg::LST_FETCH)) ? l_pol : !l_pol;
    end
  end

  assign wait_out = wait_lvl;

  fbp_word_xfer #(.W(AW)) u_addr_xfer (
    .src_clk (bus_clk),
    .dst_clk (ref_clk),
    .rst     (rst),
    .x       (a_if.mover)
  );

  fbp_word_xfer #(.W(DW)) u_data_xfer (
    .src_clk (ref_clk),
    .dst_clk (bus_clk),
    .rst     (rst),
    .x       (d_if.mover)
  );
endmodule
`default_nettype wire

// ===== test/fbp_flash_port_monitor.sv
// concurrent checks on the flash port pins
`timescale 1ns/1ps
`default_nettype none
module fbp_flash_port_monitor (
  input wire logic                       ref_clk,
  input wire logic                       rst,
  input wire logic                       chip_en_n,
  input wire logic                       out_en_n,
  input wire logic                       write_en_n,
  input wire logic                       reset_pin_n,
  input wire logic                       dq_oe,
  input wire logic                       wait_oe,
  input wire logic                       auto_rst,
  input wire logic                       wr_valid,
  input wire logic [1:0]                 dens_sel,
  input wire logic                       arr_rd_en,
  input wire logic [fbp_pkg::ADDR_W-1:0] arr_rd_addr,
  input wire logic                       unlock_req,
  input wire logic                       unlock_blk_locked,
  input wire logic                       unlock_ok,
  input wire logic                       unlock_refused,
  input wire logic                       lockdown_en
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // pin relations, four cycles allow for the synchroniser flops
  property p_desel; chip_en_n [*4] |-> !dq_oe && !wait_oe; endproperty
  a_desel: assert property (p_desel)
    else $error("outputs driven while deselected");
  property p_oe_off; out_en_n [*4] |-> !dq_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("data driven with output enable off");
  property p_wait_on; !chip_en_n [*4] |-> wait_oe; endproperty
  a_wait_on: assert property (p_wait_on)
    else $error("wait floated while selected");
  property p_rst_pin; !reset_pin_n [*4] |-> auto_rst && !wr_valid; endproperty
  a_rst_pin: assert property (p_rst_pin)
    else $error("automation free or write taken in reset");
  property p_wr;
    $rose(write_en_n) && !chip_en_n && reset_pin_n |-> ##[2:5] wr_valid;
  endproperty
  a_wr: assert property (p_wr)
    else $error("strobe rise gave no write");
  property p_dens;
    arr_rd_en && dens_sel == 2'h0 |-> arr_rd_addr[22:21] == 2'h0;
  endproperty
  a_dens: assert property (p_dens)
    else $error("address bits above density used");
  property p_lk_ref;
    unlock_req && unlock_blk_locked && lockdown_en |-> ##[1:2] unlock_refused;
  endproperty
  a_lk_ref: assert property (p_lk_ref)
    else $error("locked unlock not refused");
  property p_lk_ok;
    unlock_req && !unlock_blk_locked |-> ##[1:2] unlock_ok && !unlock_refused;
  endproperty
  a_lk_ok: assert property (p_lk_ok)
    else $error("free unlock not granted");
endmodule
`default_nettype wire

// ===== test/fbp_host_model.sv
// host controller model driving the flash port pins
`timescale 1ns/1ps
`default_nettype none
module fbp_host_model (
  input  wire logic                       ref_clk,
  output var  logic                       bus_clk,
  output var  logic [fbp_pkg::ADDR_W-1:0] addr,
  output var  logic [fbp_pkg::DATA_W-1:0] dq,
  output var  logic                       dq_drv,
  output var  logic                       adv_n,
  output var  logic                       ce_n,
  output var  logic                       oe_n,
  output var  logic                       we_n
);
  logic run;
  // idle pins; bus clock runs through reset
  initial begin
    {bus_clk, dq_drv} = 2'h0;
    run = 1'b1;
    {adv_n, ce_n, oe_n, we_n} = 4'hf;
    addr = '0;
    dq = '0;
  end
  // bus clock stands low while run is clear
  always #16 if (run || bus_clk) bus_clk = ~bus_clk;
  // select, enable and address levels
  task automatic ctl(input logic ce, input logic oe,
                     input logic [fbp_pkg::ADDR_W-1:0] a);
    @(posedge ref_clk);
    ce_n <= ce;
    oe_n <= oe;
    addr <= a;
    // strobe low while the address is valid
    adv_n <= ce;
  endtask
  // one write word
  task automatic wr_word(input logic [fbp_pkg::ADDR_W-1:0] a,
                         input logic [fbp_pkg::DATA_W-1:0] d);
    @(posedge ref_clk);
    oe_n <= 1'b1;
    ce_n <= 1'b0;
    addr <= a;
    dq <= d;
    dq_drv <= 1'b1;
    we_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    we_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    dq_drv <= 1'b0;
    dq <= ~d;
  endtask
  // synchronous burst start
  task automatic burst(input logic [fbp_pkg::ADDR_W-1:0] a);
    @(posedge ref_clk);
    addr <= a;
    adv_n <= 1'b0;
    {ce_n, oe_n} <= 2'h0;
    run <= 1'b1;
    @(posedge ref_clk);
    adv_n <= 1'b1;
  endtask
  // deselect and stop the bus clock
  task automatic halt;
    @(posedge ref_clk);
    {ce_n, oe_n, adv_n} <= 3'h7;
    // keep clocking until the port has seen the deselect
    repeat (12) @(posedge ref_clk);
    run <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== test/tb_fbp_flash_port.sv
// self-checking bench of the flash port
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  mismatches++; $display("ERROR %s exp %h got %h", n, e, g); end end
`define WT(ev, c) begin tmo = 0; while (!(c) && tmo < 300) begin \
  @(ev); tmo++; end if (!(c)) begin mismatches++; close_out(); end end
module tb_fbp_flash_port;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        reset_pin_n = 1'b1;
  logic        write_prot_n = 1'b1;
  logic [1:0]  dens_sel = 2'h2;
  logic        cfg_wr = 1'b0;
  logic [15:0] cfg_word = 16'h8400;
  logic        unlock_req = 1'b0;
  logic        unlock_blk_locked = 1'b0;
  logic [15:0] arr_rd_data = 16'h0000;
  logic        bus_clk, h_drv, adv_n, ce_n, oe_n, we_n, dq_oe;
  logic        wait_out, wait_oe, arr_rd_en, wr_valid, auto_rst, standby;
  logic        lockdown_en, unlock_ok, unlock_refused;
  logic [22:0] addr, arr_rd_addr, wr_addr;
  logic [15:0] h_dq, dq_in, dq_out, wr_data;
  logic [22:0] msk [3] = '{fbp_pkg::MASK_32M, fbp_pkg::MASK_64M,
                           fbp_pkg::MASK_128M};
  logic [2:0]  lk_tab [3] = '{3'h3, 3'h0, 3'h6};
  int          mismatches = 0;
  int          compares = 0;
  int          tmo;
  int          wr_cnt = 0;
  // clock, array contents and write pulse count
  always #50 ref_clk = ~ref_clk;
  function automatic logic [15:0] arr_word(input logic [22:0] a);
    return a[15:0] ^ 16'h3c3c;
  endfunction
  always @(posedge ref_clk) if (arr_rd_en) arr_rd_data <= arr_word(arr_rd_addr);
  always @(negedge ref_clk) if (wr_valid === 1'b1) wr_cnt++;
  // data wire level from both drivers
  assign dq_in = h_drv ? h_dq : (dq_oe ? dq_out : ~h_dq);
  fbp_host_model i_fbp_host_model (.ref_clk(ref_clk), .bus_clk(bus_clk),
    .addr(addr), .dq(h_dq), .dq_drv(h_drv), .adv_n(adv_n), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n));
  fbp_flash_port i_fbp_flash_port (.ref_clk(ref_clk), .rst(rst),
    .bus_clk(bus_clk), .addr_in(addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .addr_valid_n(adv_n), .chip_en_n(ce_n),
    .out_en_n(oe_n), .write_en_n(we_n), .reset_pin_n(reset_pin_n),
    .write_prot_n(write_prot_n), .wait_out(wait_out), .wait_oe(wait_oe),
    .dens_sel(dens_sel), .cfg_wr(cfg_wr), .cfg_word(cfg_word),
    .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr),
    .arr_rd_data(arr_rd_data), .wr_valid(wr_valid), .wr_addr(wr_addr),
    .wr_data(wr_data), .auto_rst(auto_rst), .standby(standby),
    .lockdown_en(lockdown_en), .unlock_req(unlock_req),
    .unlock_blk_locked(unlock_blk_locked), .unlock_ok(unlock_ok),
    .unlock_refused(unlock_refused));
  task automatic close_out;
    if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // async reads at each density, then output enable and deselect
  task automatic t_read;
    for (int d = 0; d < 3; d++) begin
      i_fbp_host_model.ctl(1'b1, 1'b1, 23'h000000);
      dens_sel <= d[1:0];
      repeat (3) @(posedge ref_clk);
      i_fbp_host_model.ctl(1'b0, 1'b0, 23'h7fffff);
      `WT(negedge ref_clk, arr_rd_en === 1'b1)
      `CHK("rd_addr", msk[d], arr_rd_addr)
      `WT(negedge ref_clk, dq_out === arr_word(msk[d]))
      `CHK("dq_out", arr_word(msk[d]), dq_out)
      `CHK("dq_oe", 1'b1, dq_oe)
    end
    i_fbp_host_model.ctl(1'b0, 1'b1, 23'h000000);
    repeat (4) @(negedge ref_clk);
    `CHK("dq_oe", 1'b0, dq_oe)
    `CHK("wait_oe", 1'b1, wait_oe)
    `CHK("standby", 1'b0, standby)
    i_fbp_host_model.ctl(1'b1, 1'b1, 23'h000000);
    repeat (5) @(negedge ref_clk);
    `CHK("wait_oe", 1'b0, wait_oe)
    `CHK("standby", 1'b1, standby)
  endtask
  // one write word latched at the strobe rise
  task automatic t_write;
    int c0;
    c0 = wr_cnt;
    i_fbp_host_model.wr_word(23'h5a5a5a, 16'hc3a5);
    repeat (4) @(negedge ref_clk);
    `CHK("wr_cnt", c0 + 1, wr_cnt)
    `CHK("wr_addr", 23'h5a5a5a, wr_addr)
    `CHK("wr_data", 16'hc3a5, wr_data)
  endtask
  // lock-down on and off, locked and free blocks
  task automatic t_unlock;
    logic [2:0] c;
    logic [1:0] hit;
    for (int i = 0; i < 3; i++) begin
      c = lk_tab[i];
      @(posedge ref_clk);
      write_prot_n <= c[2];
      unlock_blk_locked <= c[1];
      repeat (5) @(posedge ref_clk);
      unlock_req <= 1'b1;
      @(posedge ref_clk);
      unlock_req <= 1'b0;
      hit = 2'h0;
      repeat (3) begin
        @(negedge ref_clk);
        hit = hit | {unlock_refused, unlock_ok};
      end
      `CHK("lockdown", ~c[2], lockdown_en)
      `CHK("unlock", {c[0], ~c[0]}, hit)
    end
  endtask
  // two-word bursts with each wait polarity
  task automatic t_burst;
    logic [22:0] a;
    for (int p = 0; p < 2; p++) begin
      a = 23'h000040 + 23'(p);
      @(posedge ref_clk);
      cfg_word <= {5'h00, p[0], 10'h000};
      cfg_wr <= 1'b1;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
      repeat (5) @(posedge ref_clk);
      i_fbp_host_model.burst(a);
      for (int k = 0; k < 2; k++) begin
        `WT(negedge bus_clk, wait_out === p[0])
        `WT(negedge bus_clk, wait_out !== p[0])
        `CHK("burst", arr_word(a + 23'(k)), dq_out)
        `CHK("wait", ~p[0], wait_out)
      end
      i_fbp_host_model.halt();
    end
  endtask
  // reset pin refuses writes and brings back async reads
  task automatic t_rstpin;
    int c0;
    @(posedge ref_clk);
    reset_pin_n <= 1'b0;
    repeat (5) @(negedge ref_clk);
    `CHK("auto_rst", 1'b1, auto_rst)
    c0 = wr_cnt;
    i_fbp_host_model.wr_word(23'h000321, 16'h1234);
    repeat (6) @(negedge ref_clk);
    `CHK("wr_cnt", c0, wr_cnt)
    @(posedge ref_clk);
    reset_pin_n <= 1'b1;
    repeat (5) @(negedge ref_clk);
    `CHK("auto_rst", 1'b0, auto_rst)
    i_fbp_host_model.ctl(1'b0, 1'b0, 23'h000123);
    `WT(negedge ref_clk, dq_out === arr_word(23'h000123))
    `CHK("dq_out", arr_word(23'h000123), dq_out)
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    i_fbp_host_model.halt();
    repeat (3) @(posedge ref_clk);
    t_read();
    t_write();
    t_unlock();
    t_burst();
    t_rstpin();
    close_out();
  end
endmodule
bind fbp_flash_port fbp_flash_port_monitor i_fbp_flash_port_monitor (
  .ref_clk(ref_clk), .rst(rst), .chip_en_n(chip_en_n),
  .out_en_n(out_en_n), .write_en_n(write_en_n),
  .reset_pin_n(reset_pin_n), .dq_oe(dq_oe), .wait_oe(wait_oe),
  .auto_rst(auto_rst), .wr_valid(wr_valid), .dens_sel(dens_sel),
  .arr_rd_en(arr_rd_en), .arr_rd_addr(arr_rd_addr),
  .unlock_req(unlock_req), .unlock_blk_locked(unlock_blk_locked),
  .unlock_ok(unlock_ok), .unlock_refused(unlock_refused),
  .lockdown_en(lockdown_en));
`default_nettype wire
